// File: shared/csr_map_defs.svh
/*
  Address map constants for the system register bank and decoder.
  Assumes byte addresses of 14 bits and 32-bit aligned register words.
*/
`ifndef CSR_MAP_DEFS_SVH
`define CSR_MAP_DEFS_SVH

`define ADDR_W            14
`define DATA_W            32
`define CORE_REG_LO       14'h0000
`define CORE_REG_HI       14'h0fff
`define PRAM_LO           14'h1000
`define PRAM_HI           14'h2fff
`define SYS_DIRECT_BASE   14'h3000
`define RD_FIFO_LO        14'h0000
`define RD_FIFO_HI        14'h001c
`define WR_FIFO_LO        14'h0020
`define WR_FIFO_HI        14'h003c
`define OFS_CHIP_IDENTITY_REVISION        14'h0050
`define OFS_IRQ_CFG       14'h0054
`define OFS_IRQ_STS       14'h0058
`define OFS_IRQ_EN        14'h005c
`define OFS_BYTE_TEST     14'h0064
`define OFS_HARDWARE_CONFIG        14'h0074
`define OFS_POWER_MGMT_CONTROL      14'h0084
`define OFS_GP_TIMER_CONFIG       14'h008c
`define OFS_GP_TIMER_COUNT       14'h0090
`define OFS_FREE_RUN      14'h009c
`define OFS_RESET_CONTROL     14'h01f8
`define OFS_CORE_DATA     14'h0300
`define OFS_CORE_CMD      14'h0304
`define OFS_PRD_ADDR_LEN  14'h0308
`define OFS_PRD_CMD       14'h030c
`define OFS_PWR_ADDR_LEN  14'h0310
`define OFS_PWR_CMD       14'h0314
`define HARDWARE_CONFIG_DIRECT_BIT 12
`define BYTE_TEST_VAL     32'h87654321
`define CHIP_IDENTITY_REVISION_VAL        32'h00a50001
`define ZERO_WORD         32'h00000000
`define GP_TIMER_COUNT_BITS      16

`endif

// File: shared/csr_map_pkg.sv
/*
  Types shared by the register bank and its decoder.
  Assumes csr_map_defs.svh is on the include path.
*/
package csr_map_pkg;
  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_SYS,
    TGT_CORE_REG,
    TGT_PRAM,
    TGT_RD_FIFO,
    TGT_WR_FIFO
  } target_t;
endpackage : csr_map_pkg

// File: shared/decode_if.sv
/*
  Carries an address and mode to the decoder and the decoded target back.
  Assumes both ends sit in one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
interface decode_if;
  import csr_map_pkg::*;
  logic [13:0] addr;
  logic        direct;
  target_t     target;
  logic [13:0] sys_ofs;
  modport requester (output addr, output direct, input target, input sys_ofs);
  modport decoder   (input addr, input direct, output target, output sys_ofs);
endinterface : decode_if
`default_nettype wire

// File: design/addr_decoder.sv
/*
  Combinational address decoder for both address modes.
  Assumes a word-aligned byte address and the mode flag from the bank.
*/
`include "csr_map_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module addr_decoder
  import csr_map_pkg::*;
(
  decode_if.decoder dec
);
  logic [13:0] rel;

  always_comb begin
    rel         = dec.addr - `SYS_DIRECT_BASE;
    dec.target  = TGT_NONE;
    dec.sys_ofs = dec.addr;
    if (dec.direct) begin
      if (dec.addr <= `CORE_REG_HI) begin
        dec.target = TGT_CORE_REG;
      end else if (dec.addr >= `PRAM_LO && dec.addr <= `PRAM_HI) begin
        dec.target = TGT_PRAM;
      end else if (rel >= `OFS_CHIP_IDENTITY_REVISION && rel < `OFS_CORE_DATA) begin
        dec.target  = TGT_SYS;
        dec.sys_ofs = rel;
      end
    end else begin
      if (dec.addr <= `RD_FIFO_HI) begin
        dec.target = TGT_RD_FIFO;
      end else if (dec.addr >= `WR_FIFO_LO && dec.addr <= `WR_FIFO_HI) begin
        dec.target = TGT_WR_FIFO;
      end else if (dec.addr >= `OFS_CHIP_IDENTITY_REVISION && dec.addr <= `OFS_PWR_CMD) begin
        dec.target = TGT_SYS;
      end
    end
  end
endmodule : addr_decoder
`default_nettype wire

// File: design/csr_address_map_decoder.sv
/*
  System register bank and address decoder of a fieldbus slave controller.
  Assumes one host port (parallel or serial front end already merged into
  one word request per cycle) and a core/process RAM back end outside.
*/
// Behaviour
// - In default mode the core registers and process RAM are reached only through windows.
// - In direct mode addresses 0h to FFFh go straight to the core registers.
// - In direct mode addresses 1000h to 2FFFh go straight to the process RAM.
// - In direct mode every system register below 300h moves up by 3000h.
// - In direct mode the window registers and data FIFOs are unreachable.
// - In default mode system registers sit at 050h to 314h, only listed offsets hold one.
// - In direct mode system registers sit at 3050h to 32FCh.
// - The registers are reachable from both the parallel and the serial host port.
// - Every system register returns to its default on chip reset.
// - In default mode any read of 000h to 01Ch pops process RAM read data.
// - In default mode any write of 020h to 03Ch pushes process RAM write data.
// - The window and command registers sit at 300h to 314h and have no direct address.
// - The interrupt configuration register is at 054h or 3054h.
// - The reset control register is at 1F8h or 31F8h.
`include "csr_map_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module csr_address_map_decoder
  import csr_map_pkg::*;
#(
  parameter int unsigned AW = `ADDR_W,
  parameter int unsigned DW = `DATA_W,
  parameter logic [31:0] CHIP_IDENTITY_REVISION_VALUE = `CHIP_IDENTITY_REVISION_VAL  // Arbitrary identity value
) (
  // Clock and reset
  input  wire  logic          i_clock,
  input  wire  logic          i_rst_n,
  // Host request, merged from parallel and serial ports
  input  wire  logic          i_req,
  input  wire  logic          i_wr,
  input  wire  logic [AW-1:0] i_addr,
  input  wire  logic [DW-1:0] i_wdata,
  output logic                o_ack,
  output logic       [DW-1:0] o_rdata,
  // Core register and process RAM back end
  output logic                o_core_req,
  output logic                o_core_wr,
  output logic                o_core_is_pram,
  output logic       [AW-1:0] o_core_addr,
  output logic       [DW-1:0] o_core_wdata,
  input  wire  logic [DW-1:0] i_core_rdata,
  // Process RAM data FIFO windows
  output logic                o_fifo_pop,
  output logic                o_fifo_push,
  output logic       [DW-1:0] o_fifo_wdata,
  input  wire  logic [DW-1:0] i_fifo_rdata,
  // Mode and control state
  output logic                o_direct_mode,
  output logic                o_reset_pulse
);
  decode_if dec ();

  logic [DW-1:0] irq_cfg_ff, irq_sts_ff, irq_en_ff, pmt_ff, gp_timer_config_ff;
  logic [DW-1:0] gp_timer_count_ff, free_run_ff, hardware_config_ff, rst_ctl_ff;
  logic [DW-1:0] core_data_ff, core_cmd_ff, prd_al_ff, prd_cmd_ff, pwr_al_ff, pwr_cmd_ff;
  logic [DW-1:0] nxt_irq_cfg, nxt_irq_sts, nxt_irq_en, nxt_pmt, nxt_gp_timer_config;
  logic [DW-1:0] nxt_gp_timer_count, nxt_free_run, nxt_hardware_config, nxt_rst_ctl;
  logic [DW-1:0] nxt_core_data, nxt_core_cmd, nxt_prd_al, nxt_prd_cmd, nxt_pwr_al, nxt_pwr_cmd;
  logic          ack_ff, nxt_ack;
  logic [DW-1:0] rdata_ff, nxt_rdata;
  logic          core_req_ff, nxt_core_req, core_wr_ff, nxt_core_wr, pram_ff, nxt_pram;
  logic [AW-1:0] core_addr_ff, nxt_core_addr;
  logic [DW-1:0] core_wdata_ff, nxt_core_wdata;
  logic          pop_ff, nxt_pop, push_ff, nxt_push;
  logic [DW-1:0] fifo_wdata_ff, nxt_fifo_wdata;
  logic          rst_pulse_ff, nxt_rst_pulse;
  logic          wr_hit, rd_hit;

  assign dec.addr   = i_addr;
  assign dec.direct = hardware_config_ff[`HARDWARE_CONFIG_DIRECT_BIT];

  addr_decoder u_dec (
    .dec (dec)
  );

  // One write strobe for a given system offset
  function automatic logic sys_wr(input logic [13:0] ofs);
    sys_wr = wr_hit && dec.target == TGT_SYS && dec.sys_ofs == ofs;
  endfunction : sys_wr

  // Read-side value of one system offset; zero for holes
  function automatic logic [DW-1:0] sys_read(input logic [13:0] ofs, input logic direct);
    logic [DW-1:0] v;
    v = `ZERO_WORD;
    unique case (ofs)
      `OFS_CHIP_IDENTITY_REVISION:    v = CHIP_IDENTITY_REVISION_VALUE;
      `OFS_IRQ_CFG:   v = irq_cfg_ff;
      `OFS_IRQ_STS:   v = irq_sts_ff;
      `OFS_IRQ_EN:    v = irq_en_ff;
      `OFS_BYTE_TEST: v = `BYTE_TEST_VAL;
      `OFS_HARDWARE_CONFIG:    v = hardware_config_ff;
      `OFS_POWER_MGMT_CONTROL:  v = pmt_ff;
      `OFS_GP_TIMER_CONFIG:   v = gp_timer_config_ff;
      `OFS_GP_TIMER_COUNT:   v = gp_timer_count_ff;
      `OFS_FREE_RUN:  v = free_run_ff;
      `OFS_RESET_CONTROL: v = rst_ctl_ff;
      default:        v = `ZERO_WORD;
    endcase
    if (!direct) begin
      unique case (ofs)
        `OFS_CORE_DATA:    v = core_data_ff;
        `OFS_CORE_CMD:     v = core_cmd_ff;
        `OFS_PRD_ADDR_LEN: v = prd_al_ff;
        `OFS_PRD_CMD:      v = prd_cmd_ff;
        `OFS_PWR_ADDR_LEN: v = pwr_al_ff;
        `OFS_PWR_CMD:      v = pwr_cmd_ff;
        default:           v = v;
      endcase
    end
    sys_read = v;
  endfunction : sys_read

  always_comb begin
    wr_hit         = i_req && i_wr;
    rd_hit         = i_req && !i_wr;
    nxt_irq_cfg    = sys_wr(`OFS_IRQ_CFG)   ? i_wdata : irq_cfg_ff;
    nxt_irq_sts    = sys_wr(`OFS_IRQ_STS)   ? irq_sts_ff & ~i_wdata : irq_sts_ff;
    nxt_irq_en     = sys_wr(`OFS_IRQ_EN)    ? i_wdata : irq_en_ff;
    nxt_hardware_config     = sys_wr(`OFS_HARDWARE_CONFIG)    ? i_wdata : hardware_config_ff;
    nxt_pmt        = sys_wr(`OFS_POWER_MGMT_CONTROL)  ? i_wdata : pmt_ff;
    nxt_gp_timer_config    = sys_wr(`OFS_GP_TIMER_CONFIG)   ? i_wdata : gp_timer_config_ff;
    nxt_rst_ctl    = sys_wr(`OFS_RESET_CONTROL) ? i_wdata : `ZERO_WORD;
    nxt_rst_pulse  = sys_wr(`OFS_RESET_CONTROL) && i_wdata != `ZERO_WORD;
    nxt_gp_timer_count    = gp_timer_count_ff - {{(DW-1){1'b0}}, 1'b1};
    nxt_free_run   = free_run_ff + {{(DW-1){1'b0}}, 1'b1};
    nxt_core_data  = core_data_ff;
    nxt_core_cmd   = core_cmd_ff;
    nxt_prd_al     = prd_al_ff;
    nxt_prd_cmd    = prd_cmd_ff;
    nxt_pwr_al     = pwr_al_ff;
    nxt_pwr_cmd    = pwr_cmd_ff;
    if (!dec.direct) begin
      if (sys_wr(`OFS_CORE_DATA))    nxt_core_data = i_wdata;
      if (sys_wr(`OFS_CORE_CMD))     nxt_core_cmd  = i_wdata;
      if (sys_wr(`OFS_PRD_ADDR_LEN)) nxt_prd_al    = i_wdata;
      if (sys_wr(`OFS_PRD_CMD))      nxt_prd_cmd   = i_wdata;
      if (sys_wr(`OFS_PWR_ADDR_LEN)) nxt_pwr_al    = i_wdata;
      if (sys_wr(`OFS_PWR_CMD))      nxt_pwr_cmd   = i_wdata;
    end
    nxt_ack        = i_req;
    nxt_rdata      = `ZERO_WORD;
    nxt_core_req   = 1'b0;
    nxt_core_wr    = 1'b0;
    nxt_pram       = 1'b0;
    nxt_core_addr  = i_addr;
    nxt_core_wdata = i_wdata;
    nxt_pop        = 1'b0;
    nxt_push       = 1'b0;
    nxt_fifo_wdata = fifo_wdata_ff;
    if (i_req) begin
      unique case (dec.target)
        TGT_SYS: begin
          if (rd_hit) nxt_rdata = sys_read(dec.sys_ofs, dec.direct);
        end
        TGT_CORE_REG, TGT_PRAM: begin
          nxt_core_req = 1'b1;
          nxt_core_wr  = i_wr;
          nxt_pram     = dec.target == TGT_PRAM;
          if (rd_hit) nxt_rdata = i_core_rdata;
        end
        TGT_RD_FIFO: begin
          nxt_pop = rd_hit;
          if (rd_hit) nxt_rdata = i_fifo_rdata;
        end
        TGT_WR_FIFO: begin
          nxt_push = wr_hit;
          if (wr_hit) nxt_fifo_wdata = i_wdata;
        end
        TGT_NONE: nxt_rdata = `ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      irq_cfg_ff    <= `ZERO_WORD;
      irq_sts_ff    <= `ZERO_WORD;
      irq_en_ff     <= `ZERO_WORD;
      hardware_config_ff     <= `ZERO_WORD;
      pmt_ff        <= `ZERO_WORD;
      gp_timer_config_ff    <= `ZERO_WORD;
      gp_timer_count_ff    <= `ZERO_WORD;
      free_run_ff   <= `ZERO_WORD;
      rst_ctl_ff    <= `ZERO_WORD;
      core_data_ff  <= `ZERO_WORD;
      core_cmd_ff   <= `ZERO_WORD;
      prd_al_ff     <= `ZERO_WORD;
      prd_cmd_ff    <= `ZERO_WORD;
      pwr_al_ff     <= `ZERO_WORD;
      pwr_cmd_ff    <= `ZERO_WORD;
      ack_ff        <= 1'b0;
      rdata_ff      <= `ZERO_WORD;
      core_req_ff   <= 1'b0;
      core_wr_ff    <= 1'b0;
      pram_ff       <= 1'b0;
      core_addr_ff  <= '0;
      core_wdata_ff <= `ZERO_WORD;
      pop_ff        <= 1'b0;
      push_ff       <= 1'b0;
      fifo_wdata_ff <= `ZERO_WORD;
      rst_pulse_ff  <= 1'b0;
    end else begin
      irq_cfg_ff    <= nxt_irq_cfg;
      irq_sts_ff    <= nxt_irq_sts;
      irq_en_ff     <= nxt_irq_en;
      hardware_config_ff     <= nxt_hardware_config;
      pmt_ff        <= nxt_pmt;
      gp_timer_config_ff    <= nxt_gp_timer_config;
      gp_timer_count_ff    <= nxt_gp_timer_count;
      free_run_ff   <= nxt_free_run;
      rst_ctl_ff    <= nxt_rst_ctl;
      core_data_ff  <= nxt_core_data;
      core_cmd_ff   <= nxt_core_cmd;
      prd_al_ff     <= nxt_prd_al;
      prd_cmd_ff    <= nxt_prd_cmd;
      pwr_al_ff     <= nxt_pwr_al;
      pwr_cmd_ff    <= nxt_pwr_cmd;
      ack_ff        <= nxt_ack;
      rdata_ff      <= nxt_rdata;
      core_req_ff   <= nxt_core_req;
      core_wr_ff    <= nxt_core_wr;
      pram_ff       <= nxt_pram;
      core_addr_ff  <= nxt_core_addr;
      core_wdata_ff <= nxt_core_wdata;
      pop_ff        <= nxt_pop;
      push_ff       <= nxt_push;
      fifo_wdata_ff <= nxt_fifo_wdata;
      rst_pulse_ff  <= nxt_rst_pulse;
    end
  end

  assign o_ack          = ack_ff;
  assign o_rdata        = rdata_ff;
  assign o_core_req     = core_req_ff;
  assign o_core_wr      = core_wr_ff;
  assign o_core_is_pram = pram_ff;
  assign o_core_addr    = core_addr_ff;
  assign o_core_wdata   = core_wdata_ff;
  assign o_fifo_pop     = pop_ff;
  assign o_fifo_push    = push_ff;
  assign o_fifo_wdata   = fifo_wdata_ff;
  assign o_direct_mode  = hardware_config_ff[`HARDWARE_CONFIG_DIRECT_BIT];
  assign o_reset_pulse  = rst_pulse_ff;
endmodule : csr_address_map_decoder
`default_nettype wire

// File: testbench/csr_map_checker_assertions.sv
/*
  Concurrent checks on the ports of the register bank and decoder.
  Assumes default address and data widths and registered one-cycle answers.
*/
`timescale 1ns/1ns
`default_nettype none
module csr_map_checker (
  // Clock, reset and host request
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  input wire logic        i_req,
  input wire logic        i_wr,
  input wire logic [13:0] i_addr,
  input wire logic [31:0] i_wdata,
  // Answers
  input wire logic        o_ack,
  input wire logic        o_core_req,
  input wire logic        o_core_wr,
  input wire logic [31:0] o_core_wdata,
  input wire logic        o_core_is_pram,
  input wire logic [13:0] o_core_addr,
  input wire logic        o_fifo_pop,
  input wire logic        o_fifo_push,
  input wire logic [31:0] o_fifo_wdata,
  input wire logic        o_direct_mode,
  input wire logic        o_reset_pulse
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  AST_ACK: assert property (i_req |=> o_ack) else $error("no ack");
  AST_NO_ACK: assert property (!i_req |=> !o_ack) else $error("stray ack");
  AST_POP: assert property (i_req && !i_wr && !o_direct_mode && i_addr <= 14'h001c
    |=> o_fifo_pop) else $error("no pop");
  AST_PUSH: assert property (i_req && i_wr && !o_direct_mode && i_addr inside {[14'h0020:14'h003c]}
    |=> o_fifo_push && o_fifo_wdata == $past(i_wdata)) else $error("bad push");
  AST_CORE: assert property (i_req && o_direct_mode && i_addr < 14'h3000 |=> o_core_req
    && o_core_addr == $past(i_addr) && o_core_is_pram == ($past(i_addr) >= 14'h1000))
    else $error("bad core access");
  AST_CORE_WR: assert property (i_req && o_direct_mode && i_addr < 14'h3000
    |=> o_core_wr == $past(i_wr) && o_core_wdata == $past(i_wdata))
    else $error("bad core write");
  AST_NO_CORE: assert property (!o_direct_mode |=> !o_core_req) else $error("core leak");
  AST_NO_FIFO: assert property (o_direct_mode |=> !o_fifo_pop && !o_fifo_push)
    else $error("fifo in direct mode");
  AST_RST_PULSE: assert property (i_req && i_wr && i_wdata != 32'h0
    && i_addr == (o_direct_mode ? 14'h31f8 : 14'h01f8) |=> o_reset_pulse) else $error("no pulse");
  AST_RESET: assert property (disable iff (1'b0) !i_rst_n |=> !o_direct_mode && !o_ack)
    else $error("reset state");
endmodule : csr_map_checker
`default_nettype wire

bind csr_address_map_decoder csr_map_checker u_chk (
  .i_clock        (i_clock),
  .i_rst_n        (i_rst_n),
  .i_req          (i_req),
  .i_wr           (i_wr),
  .i_addr         (i_addr),
  .i_wdata        (i_wdata),
  .o_ack          (o_ack),
  .o_core_req     (o_core_req),
  .o_core_wr      (o_core_wr),
  .o_core_wdata   (o_core_wdata),
  .o_core_is_pram (o_core_is_pram),
  .o_core_addr    (o_core_addr),
  .o_fifo_pop     (o_fifo_pop),
  .o_fifo_push    (o_fifo_push),
  .o_fifo_wdata   (o_fifo_wdata),
  .o_direct_mode  (o_direct_mode),
  .o_reset_pulse  (o_reset_pulse)
);

// File: testbench/backend_model.sv
/*
  Back end data source: core, process RAM and read FIFO head.
  Assumes data is sampled in the request cycle, so it changes every cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module backend_model (
  // Clock
  input  wire logic        i_clock,
  // Data offered to the bank
  output var  logic [31:0] o_core_rdata,
  output var  logic [31:0] o_fifo_rdata
);
  initial o_core_rdata = 32'h13579bdf;
  always @(posedge i_clock) o_core_rdata <= o_core_rdata + 32'h01030507;
  assign o_fifo_rdata = ~o_core_rdata;
endmodule : backend_model
`default_nettype wire

// File: testbench/csr_address_map_decoder_tb_top.sv
/*
  Self-checking bench for the register bank and decoder.
  Assumes the checker is bound by its own file and the partner feeds data.
*/
`include "csr_map_defs.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module csr_address_map_decoder_tb_top;
  import csr_map_pkg::*;
  logic i_clock = 0, i_rst_n = 0, i_req = 0, i_wr = 0;
  logic [13:0] i_addr = '0, c_addr;
  logic [31:0] i_wdata = '0, i_core_rdata, i_fifo_rdata, o_rdata, o_core_wdata, o_fifo_wdata;
  logic [31:0] rd, cd, fd;
  logic o_ack, o_core_req, o_core_wr, o_core_is_pram, o_fifo_pop, o_fifo_push;
  logic o_direct_mode, o_reset_pulse, pop, push, creq, rp;
  int miscompares = 0, checks_done = 0;

  always #10 i_clock = ~i_clock;

  csr_address_map_decoder u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(i_req),
    .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata), .o_ack(o_ack), .o_rdata(o_rdata),
    .o_core_req(o_core_req), .o_core_wr(o_core_wr), .o_core_is_pram(o_core_is_pram),
    .o_core_addr(c_addr), .o_core_wdata(o_core_wdata), .i_core_rdata(i_core_rdata),
    .o_fifo_pop(o_fifo_pop), .o_fifo_push(o_fifo_push), .o_fifo_wdata(o_fifo_wdata),
    .i_fifo_rdata(i_fifo_rdata), .o_direct_mode(o_direct_mode), .o_reset_pulse(o_reset_pulse));
  backend_model u_be (.i_clock(i_clock), .o_core_rdata(i_core_rdata),
    .o_fifo_rdata(i_fifo_rdata));

  // System register address in the current mode
  function automatic logic [13:0] sys(input int dm, input logic [13:0] o);
    return (dm != 0) ? o + `SYS_DIRECT_BASE : o;
  endfunction : sys

  // One access; called just after a rising edge, returns just after one
  task automatic acc(input logic w, input logic [13:0] a, input logic [31:0] d);
    i_req <= 1'b1;
    i_wr <= w;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    cd = i_core_rdata;
    fd = i_fifo_rdata;
    i_req <= 1'b0;
    #1;
    `CHK(o_ack, 1'b1)
    rd = o_rdata; pop = o_fifo_pop; push = o_fifo_push; creq = o_core_req; rp = o_reset_pulse;
    @(posedge i_clock);
  endtask : acc

  task automatic do_reset();
    i_rst_n <= 1'b0;
    repeat (4) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
  endtask : do_reset

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge i_clock);
    miscompares++;
    wrap_up();
  end

  initial begin
    void'($urandom(60884));
    do_reset();
    for (int m = 0; m < 2; m++) begin
      acc(1'b0, sys(m, `OFS_BYTE_TEST), '0); `CHK(rd, `BYTE_TEST_VAL)
      acc(1'b0, sys(m, `OFS_CHIP_IDENTITY_REVISION), '0); `CHK(rd, `CHIP_IDENTITY_REVISION_VAL)
      acc(1'b0, sys(m, `OFS_RESET_CONTROL), '0); `CHK(rd, 32'h0)
      acc(1'b1, sys(m, `OFS_RESET_CONTROL), 32'h1); `CHK(rp, 1'b1)
      acc(1'b0, sys(m, 14'h0060), '0); `CHK(rd, 32'h0)
      acc(1'b0, 14'h001c, '0); `CHK(pop, !m)
      `CHK(rd, m ? cd : fd)
      acc(1'b1, 14'h003c, 32'h5a5a1234); `CHK(push, !m)
      acc(1'b0, 14'h1ffc, '0); `CHK(creq, m)
      acc(1'b0, 14'h3308, '0); `CHK(rd, 32'h0)
      acc(1'b1, sys(m, `OFS_PRD_ADDR_LEN), 32'h0000a5c3);
      acc(1'b0, sys(m, `OFS_PRD_ADDR_LEN), '0); `CHK(rd, (m != 0) ? 32'h0 : 32'h0000a5c3)
      acc(1'b1, sys(m, `OFS_IRQ_CFG), 32'h0000c3a0 | m);
      acc(1'b0, sys(m, `OFS_IRQ_CFG), '0); `CHK(rd, 32'h0000c3a0 | m)
      acc(1'b0, sys(m, `OFS_HARDWARE_CONFIG), '0); `CHK(rd[12], m)
      if (m == 0) begin
        acc(1'b1, `OFS_HARDWARE_CONFIG, 32'h00001000); `CHK(o_direct_mode, 1'b1)
      end
    end
    for (int k = 0; k < 3000; k++) begin
      i_req <= 1'($urandom);
      i_wr <= 1'($urandom);
      i_addr <= 14'($urandom) & 14'h3ffc;
      i_wdata <= $urandom;
      @(posedge i_clock);
    end
    i_req <= 1'b0;
    @(posedge i_clock);
    acc(1'b1, sys(o_direct_mode, `OFS_IRQ_CFG), 32'h0000ffff);
    acc(1'b1, sys(o_direct_mode, `OFS_HARDWARE_CONFIG), 32'h00001000);
    `CHK(o_direct_mode, 1'b1)
    do_reset();
    `CHK(o_direct_mode, 1'b0)
    acc(1'b0, `OFS_BYTE_TEST, '0); `CHK(rd, `BYTE_TEST_VAL)
    acc(1'b0, `OFS_IRQ_CFG, '0); `CHK(rd, 32'h0)
    wrap_up();
  end
endmodule : csr_address_map_decoder_tb_top
`default_nettype wire
